// *** hw/gpt_timers.sv ***
// Overview of operation
// RULE1: Run bit starts and stops counter
// RULE2: Idle-halt bit stops timer in Idle
// RULE3: Extended pick: secondary, pin, low-power RC
// RULE4: Gating ignored when external clock chosen
// RULE5: Prescale 1:1, 1:8, 1:64, 1:256
// RULE6: Sync select applies only to external clock
// RULE7: Clock source bit: Fosc/2 or external
// RULE8: Control write while running clears prescaler
// RULE9: Interrupt on period match or gate fall; the code raises the gate-fall event on the standalone timer only
// RULE10: Standalone: timer, sync counter, async counter
// RULE11: Timers keep running in Idle and Sleep; the internal clock stops in Sleep, only external sources keep counting
// RULE12: Join bit merges pair into 32 bits
// RULE13: Joined: upper control ignored, upper flag
// RULE14: Upper period is high word
// RULE15: Upper count is high word
// RULE16: A/D trigger only from first pair upper
// RULE17: Pair timers count synchronously only
// RULE18: Joined pair flags on 32-bit match
// RULE19: Software configures fully before setting run
// RULE20: Pair external clock counts rising pin edges
// RULE21: Match wraps to zero and flags
// RULE22: Gated mode counts only while gate high
module gpt_timers
  import gpt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic idle_mode_in,
  input wire logic sleep_mode_in,
  input wire logic secondary_osc_in,
  input wire logic low_power_rc_osc_in,
  input wire logic basic_ext_clock_pin_in,
  input wire logic [NUM_TMR-2:0] paired_ext_clock_pin_in,
  input wire logic [NUM_TMR-1:0] gate_in,
  output logic [NUM_TMR-1:0] irq_flag_out,
  output logic [NUM_TMR-1:0] tmr_event_out,
  output logic adc_trigger_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Decode: {hit, kind, timer index}
  function automatic logic [5:0] dec_addr(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    logic [3:0] ofs;
    idx = a[6:4];
    ofs = a[3:0];
    if (a == OFS_FLAGS) begin
      dec_addr = {1'b1, KIND_FLAGS, 3'h0};
    end else if (a[7] || idx > TMR_P2_HI) begin
      dec_addr = 6'h00;
    end else if (ofs == OFS_CTRL) begin
      dec_addr = {1'b1, KIND_CTRL, idx};
    end else if (ofs == OFS_PERIOD) begin
      dec_addr = {1'b1, KIND_PERIOD, idx};
    end else if (ofs == OFS_COUNT) begin
      dec_addr = {1'b1, KIND_COUNT, idx};
    end else begin
      dec_addr = 6'h00;
    end
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] strb);
    lane_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                  strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic [15:0] ctrl_mask(input int i);
    if (i == 0) begin
      ctrl_mask = CTRL_MASK_BASIC;
    end else if (i % 2 == 1) begin
      ctrl_mask = CTRL_MASK_PAIR_LO;
    end else begin
      ctrl_mask = CTRL_MASK_PAIR_HI;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] ctrl_ff [NUM_TMR];
  logic [15:0] per_ff [NUM_TMR];
  logic [15:0] cnt_ff [NUM_TMR];
  logic [15:0] nxt_cnt [NUM_TMR];
  logic [7:0] pre_ff [NUM_TMR];
  logic [NUM_TMR-1:0] sync1_ff, sync2_ff, sync3_ff, raw_d_ff, gate_d_ff;
  logic [NUM_TMR-1:0] flag_ff, ev_ff, ev, tick, src, pre_clr, gate_fall, run;
  logic fosc_ph_ff;
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_fire;
  logic [5:0] wdec, rdec;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Address and data are taken independently; the write fires once both are held
  assign axi_awready_out = !aw_held_ff && !bvalid_ff;
  assign axi_wready_out = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wdec = dec_addr(awaddr_ff);
  assign rdec = dec_addr(axi_araddr_in);
  assign axi_bvalid_out = bvalid_ff;
  assign axi_bresp_out = bresp_ff;
  // Only one read in flight; data held until rready
  assign axi_arready_out = !rvalid_ff;
  assign axi_rvalid_out = rvalid_ff;
  assign axi_rdata_out = rdata_ff;
  assign axi_rresp_out = rresp_ff;

  // Write channel capture and response
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (axi_awvalid_in && axi_awready_out) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_held_ff <= 1'b1;
        wdata_ff <= axi_wdata_in;
        wstrb_ff <= axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wdec[5] ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_ff && axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: data sampled at the address handshake
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (axi_arvalid_in && axi_arready_out) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rdec[5] ? RESP_OKAY : RESP_DECERR;
      if (!rdec[5]) begin
        rdata_ff <= 32'h0000_0000;
      end else if (rdec[4:3] == KIND_CTRL) begin
        rdata_ff <= {16'h0000, ctrl_ff[rdec[2:0]]};
      end else if (rdec[4:3] == KIND_PERIOD) begin
        rdata_ff <= {16'h0000, per_ff[rdec[2:0]]};
      end else if (rdec[4:3] == KIND_COUNT) begin
        rdata_ff <= {16'h0000, cnt_ff[rdec[2:0]]};
      end else begin
        rdata_ff <= {27'h0000000, flag_ff};
      end
    end else if (rvalid_ff && axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and period registers

  // Reserved bits never store, so they read back zero
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        ctrl_ff[i] <= CTRL_RESET;
        per_ff[i] <= PERIOD_RESET;
      end
    end else if (wr_fire && wdec[5] && wdec[4:3] == KIND_CTRL) begin
      ctrl_ff[wdec[2:0]] <= lane_merge(ctrl_ff[wdec[2:0]], wdata_ff[15:0], wstrb_ff[1:0])
                            & ctrl_mask(int'(wdec[2:0]));
    end else if (wr_fire && wdec[5] && wdec[4:3] == KIND_PERIOD) begin
      per_ff[wdec[2:0]] <= lane_merge(per_ff[wdec[2:0]], wdata_ff[15:0], wstrb_ff[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources, gating and prescalers

  // Instruction clock is Fosc/2: one internal tick every other core cycle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fosc_ph_ff <= 1'b0;
    end else begin
      fosc_ph_ff <= !fosc_ph_ff; // [RULE7]
    end
  end

  for (genvar i = 0; i < NUM_TMR; i++) begin : g_src
    logic raw, ext_edge, gate_en, cs;
    logic [1:0] ps;
    logic [7:0] tc;
    assign cs = ctrl_ff[i][BIT_CLK_SRC];
    assign ps = ctrl_ff[i][BIT_PRESC_HI:BIT_PRESC_LO];
    // Gating only means something on the internal clock
    assign gate_en = ctrl_ff[i][BIT_GATE_ACC] && !cs; // [RULE4]
    if (i == 0) begin : g_basic
      // Extended pick; code 3 has no source and never counts
      always_comb begin
        case (ctrl_ff[i][BIT_EXT_PICK_HI:BIT_EXT_PICK_LO])
          EXT_SECONDARY_OSC: raw = secondary_osc_in; // [RULE3]
          EXT_CLOCK_PIN: raw = basic_ext_clock_pin_in; // [RULE3]
          EXT_LOW_POWER_RC: raw = low_power_rc_osc_in; // [RULE3]
          default: raw = 1'b0;
        endcase
      end
      // Async mode skips the synchroniser and keeps counting in Sleep
      assign ext_edge = ctrl_ff[i][BIT_EXT_SYNC] ? (sync2_ff[i] && !sync3_ff[i])
                                                  : (raw && !raw_d_ff[i]); // [RULE6] [RULE10]
    end else begin : g_pair
      // Pair timers always synchronise their pin
      assign raw = paired_ext_clock_pin_in[i-1];
      assign ext_edge = sync2_ff[i] && !sync3_ff[i]; // [RULE17] [RULE20]
    end
    // Internal clock stops in Sleep; external sources do not
    assign src[i] = cs ? ext_edge
                       : (fosc_ph_ff && !sleep_mode_in && (!gate_en || gate_in[i])); // [RULE22] [RULE11]
    assign run[i] = ctrl_ff[i][BIT_COUNT_RUN]
                    && !(idle_mode_in && ctrl_ff[i][BIT_IDLE_HALT]); // [RULE1] [RULE2]
    always_comb begin
      case (ps)
        2'h0: tc = PRESC_TC_1;
        2'h1: tc = PRESC_TC_8;
        2'h2: tc = PRESC_TC_64;
        default: tc = PRESC_TC_256;
      endcase
    end
    assign tick[i] = run[i] && src[i] && (pre_ff[i] == tc); // [RULE5]
    assign gate_fall[i] = (i == 0) && gate_en && ctrl_ff[i][BIT_COUNT_RUN]
                          && gate_d_ff[i] && !gate_in[i]; // [RULE9]
    // Any control write to a running timer restarts its prescaler
    assign pre_clr[i] = wr_fire && wdec[5] && wdec[4:3] == KIND_CTRL
                        && wdec[2:0] == 3'(i) && ctrl_ff[i][BIT_COUNT_RUN]; // [RULE8]

    // Prescaler counts qualified source edges only
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        pre_ff[i] <= 8'h00;
      end else if (pre_clr[i] || tick[i]) begin
        pre_ff[i] <= 8'h00;
      end else if (run[i] && src[i]) begin
        pre_ff[i] <= pre_ff[i] + 8'h01; // [RULE5]
      end
    end

    // Edge detectors; sync1 feeds only sync2
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
        sync3_ff[i] <= 1'b0;
        raw_d_ff[i] <= 1'b0;
        gate_d_ff[i] <= 1'b0;
      end else begin
        sync1_ff[i] <= raw;
        sync2_ff[i] <= sync1_ff[i];
        sync3_ff[i] <= sync2_ff[i];
        raw_d_ff[i] <= raw;
        gate_d_ff[i] <= gate_in[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  // Match on a tick wraps to zero; joined pairs compare all 32 bits
  always_comb begin
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    for (int i = 0; i < NUM_TMR; i++) begin
      nxt_cnt[i] = cnt_ff[i];
      ev[i] = 1'b0;
    end
    if (tick[0]) begin
      if (cnt_ff[0] == per_ff[0]) begin
        nxt_cnt[0] = 16'h0000; // [RULE21]
        ev[0] = 1'b1; // [RULE9]
      end else begin
        nxt_cnt[0] = cnt_ff[0] + 16'h0001;
      end
    end
    ev[0] = ev[0] || gate_fall[0]; // [RULE9]
    for (int p = 0; p < 2; p++) begin
      lo = 1 + 2 * p;
      hi = lo + 1;
      if (ctrl_ff[lo][BIT_PAIR_JOIN]) begin
        // Upper control is ignored; lower tick drives both words
        if (tick[lo]) begin // [RULE12] [RULE13]
          if ({cnt_ff[hi], cnt_ff[lo]} == {per_ff[hi], per_ff[lo]}) begin // [RULE14] [RULE18]
            nxt_cnt[hi] = 16'h0000;
            nxt_cnt[lo] = 16'h0000;
            ev[hi] = 1'b1; // [RULE13]
          end else begin
            {nxt_cnt[hi], nxt_cnt[lo]} = {cnt_ff[hi], cnt_ff[lo]} + 32'h0000_0001; // [RULE15]
          end
        end
      end else begin
        for (int k = 0; k < 2; k++) begin
          if (tick[lo+k]) begin
            if (cnt_ff[lo+k] == per_ff[lo+k]) begin
              nxt_cnt[lo+k] = 16'h0000;
              ev[lo+k] = 1'b1;
            end else begin
              nxt_cnt[lo+k] = cnt_ff[lo+k] + 16'h0001;
            end
          end
        end
      end
    end
  end

  // Software writes to a count take priority over counting
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        cnt_ff[i] <= COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TMR; i++) begin
        if (wr_fire && wdec[5] && wdec[4:3] == KIND_COUNT && wdec[2:0] == 3'(i)) begin
          cnt_ff[i] <= lane_merge(cnt_ff[i], wdata_ff[15:0], wstrb_ff[1:0]);
        end else begin
          cnt_ff[i] <= nxt_cnt[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and event outputs

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_ff <= '0;
      ev_ff <= '0;
    end else begin
      ev_ff <= ev;
      if (wr_fire && wdec[5] && wdec[4:3] == KIND_FLAGS && wstrb_ff[0]) begin
        flag_ff <= (flag_ff & ~wdata_ff[NUM_TMR-1:0]) | ev;
      end else begin
        flag_ff <= flag_ff | ev; // [RULE9]
      end
    end
  end

  assign irq_flag_out = flag_ff;
  assign tmr_event_out = ev_ff;
  // Upper timer of the first pair covers both its 16-bit and joined cases
  assign adc_trigger_out = ev_ff[TMR_P1_HI]; // [RULE16]

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_stopped_hold;
    @(posedge core_clk_in) disable iff (!rstn_in)
      !ctrl_ff[TMR_BASIC][BIT_COUNT_RUN] && !(wr_fire && wdec[4:3] == KIND_COUNT)
      |=> cnt_ff[TMR_BASIC] == $past(cnt_ff[TMR_BASIC]);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped timer moved"); // [RULE1]

  property p_idle_halt;
    @(posedge core_clk_in) disable iff (!rstn_in)
      idle_mode_in && ctrl_ff[TMR_BASIC][BIT_IDLE_HALT] |-> !tick[TMR_BASIC];
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("tick during idle halt"); // [RULE2]

  property p_presc_eight;
    @(posedge core_clk_in) disable iff (!rstn_in)
      tick[TMR_BASIC] && ctrl_ff[TMR_BASIC][BIT_PRESC_HI:BIT_PRESC_LO] == 2'h1
      |-> pre_ff[TMR_BASIC] == PRESC_TC_8;
  endproperty
  a_presc_eight: assert property (p_presc_eight) else $error("1:8 tick off count"); // [RULE5]

  property p_ctrl_wr_clear;
    @(posedge core_clk_in) disable iff (!rstn_in)
      pre_clr[TMR_BASIC] |=> pre_ff[TMR_BASIC] == 8'h00;
  endproperty
  a_ctrl_wr_clear: assert property (p_ctrl_wr_clear) else $error("prescaler not reset"); // [RULE8]

  property p_match_wrap;
    @(posedge core_clk_in) disable iff (!rstn_in)
      tick[TMR_BASIC] && cnt_ff[TMR_BASIC] == per_ff[TMR_BASIC]
      && !(wr_fire && wdec[4:3] == KIND_COUNT)
      |=> cnt_ff[TMR_BASIC] == 16'h0000 && flag_ff[TMR_BASIC] && tmr_event_out[TMR_BASIC];
  endproperty
  a_match_wrap: assert property (p_match_wrap) else $error("match did not wrap"); // [RULE21]

  property p_adc_source;
    @(posedge core_clk_in) disable iff (!rstn_in)
      adc_trigger_out |-> $past(ev[TMR_P1_HI]) && !$past(ev[TMR_P2_HI] && !ev[TMR_P1_HI]);
  endproperty
  a_adc_source: assert property (p_adc_source) else $error("stray A/D trigger"); // [RULE16]

  property p_joined_lo_quiet;
    @(posedge core_clk_in) disable iff (!rstn_in)
      ctrl_ff[TMR_P1_LO][BIT_PAIR_JOIN] |=> !tmr_event_out[TMR_P1_LO];
  endproperty
  a_joined_lo_quiet: assert property (p_joined_lo_quiet) else $error("low flag while joined"); // [RULE13]

  property p_gate_low;
    @(posedge core_clk_in) disable iff (!rstn_in)
      ctrl_ff[TMR_BASIC][BIT_GATE_ACC] && !ctrl_ff[TMR_BASIC][BIT_CLK_SRC] && !gate_in[TMR_BASIC]
      |-> !tick[TMR_BASIC];
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("count with gate low"); // [RULE22]

endmodule

// *** common/gpt_pkg.sv ***
package gpt_pkg;
  // Timer slots: 0 standalone, 1/2 first pair low/high, 3/4 second pair low/high
  localparam int NUM_TMR = 5;
  localparam int ADDR_W = 8;
  localparam logic [2:0] TMR_BASIC = 3'h0;
  localparam logic [2:0] TMR_P1_LO = 3'h1;
  localparam logic [2:0] TMR_P1_HI = 3'h2;
  localparam logic [2:0] TMR_P2_LO = 3'h3;
  localparam logic [2:0] TMR_P2_HI = 3'h4;

  // Register map: each timer owns a 16-byte slot
  localparam logic [7:0] TMR_STRIDE = 8'h10;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PERIOD = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam logic [7:0] OFS_FLAGS = 8'h50;

  // Register kinds seen by the address decoder
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_PERIOD = 2'h1;
  localparam logic [1:0] KIND_COUNT = 2'h2;
  localparam logic [1:0] KIND_FLAGS = 2'h3;

  // Control register fields
  localparam int BIT_COUNT_RUN = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_EXT_PICK_HI = 9;
  localparam int BIT_EXT_PICK_LO = 8;
  localparam int BIT_GATE_ACC = 6;
  localparam int BIT_PRESC_HI = 5;
  localparam int BIT_PRESC_LO = 4;
  localparam int BIT_PAIR_JOIN = 3;
  localparam int BIT_EXT_SYNC = 2;
  localparam int BIT_CLK_SRC = 1;

  // Writable bits per control register kind; others read as zero
  localparam logic [15:0] CTRL_MASK_BASIC = 16'ha376;
  localparam logic [15:0] CTRL_MASK_PAIR_LO = 16'ha07a;
  localparam logic [15:0] CTRL_MASK_PAIR_HI = 16'ha072;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Extended clock picks for the standalone timer
  localparam logic [1:0] EXT_SECONDARY_OSC = 2'h0;
  localparam logic [1:0] EXT_CLOCK_PIN = 2'h1;
  localparam logic [1:0] EXT_LOW_POWER_RC = 2'h2;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PRESC_TC_1 = 8'h00;
  localparam logic [7:0] PRESC_TC_8 = 8'h07;
  localparam logic [7:0] PRESC_TC_64 = 8'h3f;
  localparam logic [7:0] PRESC_TC_256 = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** tb/tb_gpt_timers.sv ***
module tb_gpt_timers
  import gpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk_in, rstn_in, aw_valid, w_valid, b_ready, ar_valid, idle_mode, sleep_mode;
  logic [7:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [3:0] w_strb, pair_pin;
  logic [2:0] ext_src;
  logic [4:0] gate, irq_flag, tmr_event;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, adc_trig, r_ready;
  logic [1:0] b_resp, r_resp;
  int fail_count = 0;
  int samples_checked = 0;
  int ev_cnt [5] = '{default: 0};
  int adc_cnt = 0;
  int c, e, a;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [7:0] lo;
  // Register table: address, write value, readback, response
  logic [7:0] row_ad [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h44, 8'h48, 8'h60, 8'h0c};
  logic [15:0] row_rd [9] = '{16'h7fff & CTRL_MASK_BASIC, 16'h7fff & CTRL_MASK_PAIR_LO,
    16'h7fff & CTRL_MASK_PAIR_HI, 16'h7fff & CTRL_MASK_PAIR_LO, 16'h7fff & CTRL_MASK_PAIR_HI,
    16'h1234, 16'h0abc, 16'h0000, 16'h0000};
  logic [15:0] row_wd [9] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h1234,
    16'h0abc, 16'hffff, 16'hffff};
  logic [1:0] row_rs [9] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY,
    RESP_OKAY, RESP_DECERR, RESP_DECERR};
  int divs [4] = '{1, 8, 64, 256};

  gpt_timers gpt_timers_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .axi_awaddr_in(aw_addr), .axi_awvalid_in(aw_valid), .axi_awready_out(aw_ready),
    .axi_wdata_in(w_data), .axi_wstrb_in(w_strb), .axi_wvalid_in(w_valid),
    .axi_wready_out(w_ready), .axi_bresp_out(b_resp), .axi_bvalid_out(b_valid),
    .axi_bready_in(b_ready), .axi_araddr_in(ar_addr), .axi_arvalid_in(ar_valid),
    .axi_arready_out(ar_ready), .axi_rdata_out(r_data), .axi_rresp_out(r_resp),
    .axi_rvalid_out(r_valid), .axi_rready_in(r_ready), .idle_mode_in(idle_mode),
    .sleep_mode_in(sleep_mode),
    .secondary_osc_in(ext_src[0]), .low_power_rc_osc_in(ext_src[2]),
    .basic_ext_clock_pin_in(ext_src[1]), .paired_ext_clock_pin_in(pair_pin),
    .gate_in(gate), .irq_flag_out(irq_flag), .tmr_event_out(tmr_event),
    .adc_trigger_out(adc_trig)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  // Event pulse counters; pulses last one cycle so every edge is looked at
  always @(posedge core_clk_in) begin
    for (int i = 0; i < 5; i++) if (tmr_event[i] === 1'b1) ev_cnt[i] <= ev_cnt[i] + 1;
    if (adc_trig === 1'b1) adc_cnt <= adc_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      fail_count++;
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] ad, input logic [15:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    aw_addr <= ad;
    w_data <= {16'h0000, d};
    w_strb <= 4'h3;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
    end while (b_valid !== 1'b1);
    r = b_resp;
    b_ready <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] ad, input logic [15:0] d);
    logic [1:0] r;
    wr(ad, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    ar_addr <= ad;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do @(posedge core_clk_in); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    do @(posedge core_clk_in); while (r_valid !== 1'b1);
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
  endtask

  // Count register sampled twice, with ten cycles waited between the two reads
  task automatic moves(input logic [7:0] ad, input logic exp);
    logic [31:0] v1;
    logic [31:0] v2;
    rd(ad, v1, rr);
    repeat (10) @(posedge core_clk_in);
    rd(ad, v2, rr);
    chk({31'h0, v1 !== v2}, {31'h0, exp}, "count motion");
  endtask

  // Cycles until the next event of slot i, bounded
  task automatic wait_ev(input int i, output int n);
    int s;
    s = ev_cnt[i];
    n = 0;
    while (ev_cnt[i] == s && n < 3000) begin
      @(posedge core_clk_in);
      n++;
    end
  endtask

  // Slow pulses on a standalone source (0..2) or a pair pin (3..6)
  task automatic pulse(input int w, input int n);
    repeat (n) begin
      @(posedge core_clk_in);
      if (w < 3) ext_src[w] <= 1'b1; else pair_pin[w - 3] <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      if (w < 3) ext_src[w] <= 1'b0; else pair_pin[w - 3] <= 1'b0;
      repeat (3) @(posedge core_clk_in);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (80000) @(posedge core_clk_in);
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    fail_count++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn_in, aw_valid, w_valid, b_ready, ar_valid, r_ready, idle_mode, sleep_mode} = '0;
    {aw_addr, ar_addr, w_data, w_strb, pair_pin, ext_src, gate} = '0;
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      rd({s[3:0], 4'h0}, rv, rr);
      chk(rv, {16'h0, CTRL_RESET}, "control reset");
      rd({s[3:0], 4'h4}, rv, rr);
      chk(rv, {16'h0, PERIOD_RESET}, "period reset");
      rd({s[3:0], 4'h8}, rv, rr);
      chk(rv, {16'h0, COUNT_RESET}, "count reset");
    end
    // Ordinary register cases from the table
    for (int k = 0; k < 9; k++) begin
      wr(row_ad[k], row_wd[k], rr);
      chk({30'h0, rr}, {30'h0, row_rs[k]}, "row write response");
      rd(row_ad[k], rv, rr);
      chk(rv, {16'h0, row_rd[k]}, "row readback");
      chk({30'h0, rr}, {30'h0, row_rs[k]}, "row read response");
    end
    for (int s = 0; s < 5; s++) wreg({s[3:0], 4'h0}, 16'h0000);
    // Prescale ratios, internal tick every second cycle, period 1
    wreg(8'h04, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wreg(8'h00, {10'h200, 2'(k), 4'h0});
      wait_ev(0, c);
      wait_ev(0, c);
      chk(32'(c), 32'(4 * divs[k]), "event spacing");
    end
    wreg(8'h00, 16'h0000);
    moves(8'h08, 1'b0);
    wreg(8'h04, 16'hffff);
    @(posedge core_clk_in);
    idle_mode <= 1'b1;
    wreg(8'h00, 16'ha000);
    moves(8'h08, 1'b0);
    wreg(8'h00, 16'h8000);
    moves(8'h08, 1'b1);
    @(posedge core_clk_in);
    idle_mode <= 1'b0;
    // Gated accumulation, then a gate fall raises an event
    wreg(8'h00, 16'h8040);
    moves(8'h08, 1'b0);
    @(posedge core_clk_in);
    gate[0] <= 1'b1;
    moves(8'h08, 1'b1);
    e = ev_cnt[0];
    gate[0] <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    chk(32'(ev_cnt[0] - e), 32'd1, "gate fall event");
    // Control rewrites while running keep the prescaler from expiring
    wreg(8'h04, 16'h0000);
    wreg(8'h08, 16'h0000);
    wreg(8'h00, 16'h8010);
    wait_ev(0, c);
    e = ev_cnt[0];
    repeat (10) wreg(8'h00, 16'h8010);
    chk(32'(ev_cnt[0] - e), 32'd0, "prescaler cleared by writes");
    // External picks in Sleep; gating ignored, async only on the pin
    wreg(8'h04, 16'h0001);
    @(posedge core_clk_in);
    sleep_mode <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wreg(8'h08, 16'h0000);
      wreg(8'h00, {6'h20, 2'(k), 4'h4, (k == 1) ? 4'h2 : 4'h6});
      e = ev_cnt[0];
      for (int j = 0; j < 3; j++) if (j != k) pulse(j, 3);
      chk(32'(ev_cnt[0] - e), 32'd0, "unselected source");
      pulse(k, 2);
      repeat (6) @(posedge core_clk_in);
      chk(32'(ev_cnt[0] - e), 32'd1, "selected source");
    end
    wreg(8'h00, 16'h0000);
    @(posedge core_clk_in);
    sleep_mode <= 1'b0;
    // Pair low timer on its pin; no converter trigger from it
    wreg(8'h18, 16'h0000);
    wreg(8'h14, 16'h0002);
    wreg(8'h10, 16'h8002);
    e = ev_cnt[1];
    a = adc_cnt;
    pulse(3, 3);
    repeat (8) @(posedge core_clk_in);
    chk(32'(ev_cnt[1] - e), 32'd1, "pair pin edges");
    chk(32'(adc_cnt - a), 32'd0, "no trigger from low timer");
    wreg(8'h10, 16'h0000);
    // Joined pairs: 32-bit period 0x00010000, upper control set slow
    for (int k = 0; k < 2; k++) begin
      lo = 8'h10 + 8'(k * 32);
      wreg(lo, 16'h0008);
      wreg(lo + 8'h10, 16'h0030);
      wreg(lo + 8'h04, 16'h0000);
      wreg(lo + 8'h14, 16'h0001);
      wreg(lo + 8'h08, 16'hfffc);
      wreg(lo + 8'h18, 16'h0000);
      e = ev_cnt[1 + 2 * k];
      a = adc_cnt;
      wreg(lo, 16'h8008);
      wait_ev(2 + 2 * k, c);
      wreg(lo, 16'h0008);
      chk(32'(c < 24), 32'd1, "32-bit match");
      chk(32'(ev_cnt[1 + 2 * k] - e), 32'd0, "no lower flag");
      chk(32'(adc_cnt - a), (k == 0) ? 32'd1 : 32'd0, "converter trigger");
      // Carry into the upper count word
      wreg(lo + 8'h14, 16'h0005);
      wreg(lo + 8'h08, 16'hfff0);
      wreg(lo + 8'h18, 16'h0000);
      wreg(lo, 16'h8008);
      repeat (40) @(posedge core_clk_in);
      wreg(lo, 16'h0008);
      rd(lo + 8'h18, rv, rr);
      chk(rv, 32'h1, "upper count word");
      rd(lo + 8'h08, rv, rr);
      chk(rv & 32'hffff_fff0, 32'h0, "lower count word");
    end
    // Sticky flags, cleared by writing ones
    rd({4'h0, OFS_FLAGS[3:0]} | OFS_FLAGS, rv, rr);
    chk(rv, 32'h17, "flags");
    wreg(OFS_FLAGS, 16'h001f);
    chk({27'h0, irq_flag}, 32'h0, "flags cleared");
    end_of_test();
  end
endmodule
